// File: spic_bg_regs.sv
/*
 * sub-picture overlay and background register bank with axi4-lite slave,
 * 16-entry palette, vertical phase/weight stepper and sub-picture pixel decode.
 * assumes engine-side inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module spic_bg_regs
    import spic_bg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // axi4-lite write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // engine status
    input wire logic frame_start,
    input wire logic motion_comp_unit_src,
    input wire logic [7:0] motion_comp_unit_flips,
    input wire logic out_field,
    input wire logic cur_field,
    input wire logic [1:0] cur_buf_id,
    input wire logic src_is_yuv,
    // vertical stepper
    input wire logic line_step,
    output logic [5:0] src_line_inc_q,
    output logic [6:0] bilinear_weight_q,
    // sub-picture pixel decode
    input wire logic spic_pixel_valid,
    input wire logic [31:0] spic_pixel,
    output logic spic_out_valid_q,
    output logic [7:0] spic_alpha_q,
    output logic [7:0] spic_y_q,
    output logic [7:0] spic_u_q,
    output logic [7:0] spic_v_q,
    // configuration to the engine
    output logic [29:0] bg_color_q,
    output logic [10:0] bg_hoffset_q,
    output logic [10:0] bg_voffset_q,
    output logic [24:0] residue_addr_q,
    output logic [1:0] residue_loc_q,
    output logic [24:0] overlay_addr_q,
    output logic [1:0] overlay_loc_q,
    output logic [9:0] overlay_stride_q,
    output logic scale_first_q,
    output logic blend_active_q
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        merge = (res & mask) | (old & ~mask);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == OFF_VERT_SCALE) || (a == OFF_BG_COLOR) || (a == OFF_RESIDUE) ||
                 (a == OFF_STRIDE_CTRL) || (a == OFF_OVERLAY_START) ||
                 (a == OFF_PALETTE_CTRL) || (a == OFF_BG_OFFSET);
    endfunction

    // ****************************************************************
    // write address and data capture
    // ****************************************************************
    logic aw_have_q, w_have_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [11:0] wa;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wa = {aw_addr_q[11:2], 2'b00};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    logic [31:0] vscale_q, color_q, residue_q, stride_q, overlay_q, pal_ctrl_q, offset_q;
    logic [7:0] flip_count_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vscale_q <= REG_RESET;
            color_q <= REG_RESET;
            residue_q <= REG_RESET;
            stride_q <= REG_RESET;
            overlay_q <= REG_RESET;
            pal_ctrl_q <= REG_RESET;
            offset_q <= REG_RESET;
        end else if (wr_fire) begin
            case (wa)
                OFF_VERT_SCALE: vscale_q <= merge(vscale_q, w_data_q, w_strb_q, MASK_VERT_SCALE);
                OFF_BG_COLOR: color_q <= merge(color_q, w_data_q, w_strb_q, MASK_BG_COLOR);
                OFF_RESIDUE: residue_q <= merge(residue_q, w_data_q, w_strb_q, MASK_ADDR_LOC);
                OFF_STRIDE_CTRL: stride_q <= merge(stride_q, w_data_q, w_strb_q, MASK_STRIDE_CTRL);
                OFF_OVERLAY_START: overlay_q <= merge(overlay_q, w_data_q, w_strb_q, MASK_ADDR_LOC);
                OFF_PALETTE_CTRL: pal_ctrl_q <= merge(pal_ctrl_q, w_data_q, w_strb_q, MASK_PALETTE_CTRL);
                OFF_BG_OFFSET: offset_q <= merge(offset_q, w_data_q, w_strb_q, MASK_BG_OFFSET);
                default: ;
            endcase
        end
    end

    // frame start load wins over a software write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flip_count_q <= 8'h00;
        end else if (frame_start && motion_comp_unit_src) begin
            flip_count_q <= motion_comp_unit_flips;
        end else if (wr_fire && wa == OFF_STRIDE_CTRL && !motion_comp_unit_src) begin
            flip_count_q <= w_strb_q[3] ? w_data_q[31:24] : flip_count_q;
        end
    end

    // ****************************************************************
    // palette
    // ****************************************************************
    logic [7:0] pal_y [PAL_ENTRIES];
    logic [7:0] pal_u [PAL_ENTRIES];
    logic [7:0] pal_v [PAL_ENTRIES];
    logic [31:0] pal_wr;
    logic [3:0] pal_idx;

    assign pal_wr = merge(pal_ctrl_q, w_data_q, w_strb_q, MASK_PALETTE_CTRL);
    assign pal_idx = pal_wr[PAL_ADDR_LO +: 4];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PAL_ENTRIES; i++) begin
                pal_y[i] <= 8'h00;
                pal_u[i] <= 8'h00;
                pal_v[i] <= 8'h00;
            end
        end else if (wr_fire && wa == OFF_PALETTE_CTRL) begin
            if (pal_wr[PAL_Y_WE_BIT]) begin
                pal_y[pal_idx] <= pal_wr[PAL_Y_LO +: 8];
            end
            if (pal_wr[PAL_U_WE_BIT]) begin
                pal_u[pal_idx] <= pal_wr[PAL_U_LO +: 8];
            end
            if (pal_wr[PAL_V_WE_BIT]) begin
                pal_v[pal_idx] <= pal_wr[PAL_V_LO +: 8];
            end
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    logic [11:0] ra;
    logic [31:0] status_word;

    assign ra = {s_axi_araddr[11:2], 2'b00};
    always_comb begin
        status_word = residue_q;
        status_word[RES_OUT_FIELD_BIT] = out_field;
        status_word[RES_CUR_FIELD_BIT] = cur_field;
        status_word[RES_BUF_ID_LO +: 2] = cur_buf_id;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
            case (ra)
                OFF_VERT_SCALE: s_axi_rdata <= vscale_q;
                OFF_BG_COLOR: s_axi_rdata <= color_q;
                OFF_RESIDUE: s_axi_rdata <= status_word;
                OFF_STRIDE_CTRL: s_axi_rdata <= {flip_count_q, stride_q[23:0]};
                OFF_OVERLAY_START: s_axi_rdata <= overlay_q;
                OFF_PALETTE_CTRL: s_axi_rdata <= pal_ctrl_q;
                OFF_BG_OFFSET: s_axi_rdata <= offset_q;
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // configuration outputs
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            blend_active_q <= 1'b0;
        end else begin
            blend_active_q <= stride_q[SC_ENABLE_BIT] && src_is_yuv;
        end
    end

    assign bg_color_q = color_q[29:0];
    assign bg_hoffset_q = offset_q[26:16];
    assign bg_voffset_q = offset_q[10:0];
    assign residue_addr_q = residue_q[28:4];
    assign residue_loc_q = residue_q[1:0];
    assign overlay_addr_q = overlay_q[28:4];
    assign overlay_loc_q = overlay_q[1:0];
    assign overlay_stride_q = stride_q[13:4];
    assign scale_first_q = stride_q[SC_ORDER_BIT];

    // ****************************************************************
    // vertical phase stepper
    // ****************************************************************
    logic [11:0] phase_q;
    logic [12:0] phase_sum;
    logic [6:0] weight_rnd;

    // factor holds src/(dst+0.5) when scaling down, src/dst when up
    assign phase_sum = {1'b0, phase_q} + {1'b0, vscale_q[VS_FRAC_BITS-1:0]};
    assign weight_rnd = {1'b0, phase_sum[11:6]} + {6'h00, phase_sum[5]};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 12'h000;
            src_line_inc_q <= 6'h00;
            bilinear_weight_q <= 7'h00;
        end else if (frame_start) begin
            phase_q <= 12'h000;
            bilinear_weight_q <= 7'h00;
        end else if (line_step && vscale_q[VS_ENABLE_BIT]) begin
            phase_q <= phase_sum[11:0];
            src_line_inc_q <= {1'b0, vscale_q[VS_INT_HI:VS_INT_LO]} + {5'h00, phase_sum[12]};
            bilinear_weight_q <= weight_rnd;
        end
    end

    // ****************************************************************
    // sub-picture pixel decode
    // ****************************************************************
    logic [3:0] a4, i4;

    always_comb begin
        a4 = stride_q[SC_SWAP_BIT] ? spic_pixel[3:0] : spic_pixel[7:4];
        i4 = stride_q[SC_SWAP_BIT] ? spic_pixel[7:4] : spic_pixel[3:0];
        if (stride_q[SC_INV_ALPHA_BIT]) begin
            a4 = ~a4;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spic_out_valid_q <= 1'b0;
            spic_alpha_q <= 8'h00;
            spic_y_q <= 8'h00;
            spic_u_q <= 8'h00;
            spic_v_q <= 8'h00;
        end else begin
            spic_out_valid_q <= spic_pixel_valid;
            if (spic_pixel_valid && stride_q[SC_FORMAT_BIT]) begin
                spic_alpha_q <= spic_pixel[31:24];
                spic_y_q <= spic_pixel[23:16];
                spic_u_q <= spic_pixel[15:8];
                spic_v_q <= spic_pixel[7:0];
            end else if (spic_pixel_valid) begin
                spic_alpha_q <= {a4, a4};
                spic_y_q <= pal_y[i4];
                spic_u_q <= pal_u[i4];
                spic_v_q <= pal_v[i4];
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_BLEND_RGB: assert property (!src_is_yuv |=> !blend_active_q)
        else $error("blend active on rgb source");
    AST_FLIP_LOAD: assert property (frame_start && motion_comp_unit_src |=>
        flip_count_q == $past(motion_comp_unit_flips)) else $error("flip count not loaded");
    AST_FLIP_RO: assert property (wr_fire && wa == OFF_STRIDE_CTRL && motion_comp_unit_src
        && !frame_start |=> $stable(flip_count_q)) else $error("flip count written");
    AST_PAL_WR: assert property (wr_fire && wa == OFF_PALETTE_CTRL && pal_wr[PAL_Y_WE_BIT]
        |=> pal_y[$past(pal_idx)] == $past(pal_wr[15:8])) else $error("palette luma not written");
    AST_PAL_HOLD: assert property (wr_fire && wa == OFF_PALETTE_CTRL
        && !pal_wr[PAL_V_WE_BIT] |=> pal_v[$past(pal_idx)] == $past(pal_v[pal_idx]))
        else $error("palette red-difference written without enable");
    AST_WEIGHT: assert property (line_step && vscale_q[VS_ENABLE_BIT] && !frame_start
        |=> {bilinear_weight_q, 6'h00} <= {1'b0, phase_q} + 13'h0020
        && {bilinear_weight_q, 6'h00} + 13'h0020 >= {1'b0, phase_q})
        else $error("bilinear weight not on nearest 1/64 step");
    AST_AI44: assert property (spic_pixel_valid && !stride_q[SC_FORMAT_BIT]
        && !stride_q[SC_SWAP_BIT] && !stride_q[SC_INV_ALPHA_BIT]
        |=> spic_alpha_q[3:0] == $past(spic_pixel[7:4])) else $error("alpha nibble wrong");
    AST_INV: assert property (spic_pixel_valid && !stride_q[SC_FORMAT_BIT]
        && stride_q[SC_SWAP_BIT] && stride_q[SC_INV_ALPHA_BIT]
        |=> spic_alpha_q[3:0] == ~$past(spic_pixel[3:0])) else $error("alpha not inverted");
    AST_AYUV: assert property (spic_pixel_valid && stride_q[SC_FORMAT_BIT] |=>
        spic_alpha_q == $past(spic_pixel[31:24]) && spic_v_q == $past(spic_pixel[7:0]))
        else $error("32-bit sub-picture pixel decoded wrongly");
    AST_BRESP: assert property (wr_fire || s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response missing");
    COV_PAL: cover property (wr_fire && wa == OFF_PALETTE_CTRL && pal_wr[2:0] == 3'h7);
    COV_MOTION_FRAME: cover property (frame_start && motion_comp_unit_src);
    COV_UNMAPPED: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    COV_AYUV: cover property (spic_pixel_valid && stride_q[SC_FORMAT_BIT] && blend_active_q);

endmodule // spic_bg_regs

// File: spic_bg_pkg.sv
/*
 * constants for the sub-picture overlay and background register bank:
 * byte offsets, field positions, writable masks and reset values.
 * assumes a 32-bit axi4-lite register bus with 12-bit byte addresses.
 */
package spic_bg_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFF_VERT_SCALE = 12'h3b4;
    localparam logic [11:0] OFF_BG_COLOR = 12'h3b8;
    localparam logic [11:0] OFF_RESIDUE = 12'h3bc;
    localparam logic [11:0] OFF_STRIDE_CTRL = 12'h3c0;
    localparam logic [11:0] OFF_OVERLAY_START = 12'h3c4;
    localparam logic [11:0] OFF_PALETTE_CTRL = 12'h3c8;
    localparam logic [11:0] OFF_BG_OFFSET = 12'h3cc;

    // ****************************************************************
    // writable bit masks and reset value
    // ****************************************************************
    localparam logic [31:0] MASK_VERT_SCALE = 32'h9001ffff;
    localparam logic [31:0] MASK_BG_COLOR = 32'h3fffffff;
    localparam logic [31:0] MASK_ADDR_LOC = 32'h1ffffff3;
    localparam logic [31:0] MASK_STRIDE_CTRL = 32'h001f3ff0;
    localparam logic [31:0] MASK_FLIP_COUNT = 32'hff000000;
    localparam logic [31:0] MASK_PALETTE_CTRL = 32'hfffffff7;
    localparam logic [31:0] MASK_BG_OFFSET = 32'h07ff07ff;
    localparam logic [31:0] REG_RESET = 32'h00000000;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int VS_ENABLE_BIT = 31;
    localparam int VS_DOWN_BIT = 28;
    localparam int VS_INT_HI = 16;
    localparam int VS_INT_LO = 12;
    localparam int VS_FRAC_BITS = 12;
    localparam int WEIGHT_FRAC_BITS = 6;
    localparam logic [6:0] WEIGHT_MAX = 7'h40;
    localparam int RES_OUT_FIELD_BIT = 31;
    localparam int RES_CUR_FIELD_BIT = 30;
    localparam int RES_BUF_ID_LO = 2;
    localparam int SC_ORDER_BIT = 20;
    localparam int SC_FORMAT_BIT = 19;
    localparam int SC_INV_ALPHA_BIT = 18;
    localparam int SC_SWAP_BIT = 17;
    localparam int SC_ENABLE_BIT = 16;
    localparam int PAL_V_LO = 24;
    localparam int PAL_U_LO = 16;
    localparam int PAL_Y_LO = 8;
    localparam int PAL_ADDR_LO = 4;
    localparam int PAL_V_WE_BIT = 2;
    localparam int PAL_U_WE_BIT = 1;
    localparam int PAL_Y_WE_BIT = 0;
    localparam int PAL_ENTRIES = 16;

    // ****************************************************************
    // bus responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: test_video_subpicture_background_regs.sv
/* self-checking testbench for spic_bg_regs: axi4-lite register access,
   engine status inputs, palette fill and sub-picture pixel decode.
   assumes spic_bg_pkg and spic_bg_regs are compiled before this file. */
`timescale 1ns/1ps
module test_video_subpicture_background_regs import spic_bg_pkg::*;;
    // ****************************************************************
    // signals and helpers
    // ****************************************************************
    localparam logic [11:0] OFFS [7] = '{OFF_VERT_SCALE, OFF_BG_COLOR, OFF_RESIDUE,
        OFF_STRIDE_CTRL, OFF_OVERLAY_START, OFF_PALETTE_CTRL, OFF_BG_OFFSET};
    localparam logic [31:0] MASKS [7] = '{MASK_VERT_SCALE, MASK_BG_COLOR, MASK_ADDR_LOC,
        MASK_STRIDE_CTRL | MASK_FLIP_COUNT, MASK_ADDR_LOC, MASK_PALETTE_CTRL, MASK_BG_OFFSET};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, pix = '0;
    logic [3:0] wstrb = '0;
    logic fstart = 1'b0, mcsrc = 1'b0, ofld = 1'b0, cfld = 1'b0, yuv = 1'b0, pvld = 1'b0;
    logic lstep = 1'b0;
    logic [7:0] mcfc = '0;
    logic [1:0] bufid = '0;
    logic awready, wready, bvalid, arready, rvalid, ovld, sfirst, bact;
    logic [1:0] bresp, rresp, rloc, oloc;
    logic [31:0] rdata;
    logic [5:0] linc;
    logic [6:0] wgt;
    logic [7:0] pa, py, pu, pv;
    logic [29:0] bgc;
    logic [10:0] hoff, voff;
    logic [24:0] raddr, oaddr;
    logic [9:0] ostr;
    logic [7:0] pal_y [16], pal_u [16], pal_v [16];
    int num_errors = 0;
    int n_compared = 0;

    spic_bg_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .frame_start(fstart), .motion_comp_unit_src(mcsrc),
        .motion_comp_unit_flips(mcfc), .out_field(ofld), .cur_field(cfld), .cur_buf_id(bufid),
        .src_is_yuv(yuv), .line_step(lstep), .src_line_inc_q(linc),
        .bilinear_weight_q(wgt), .spic_pixel_valid(pvld), .spic_pixel(pix),
        .spic_out_valid_q(ovld), .spic_alpha_q(pa), .spic_y_q(py), .spic_u_q(pu),
        .spic_v_q(pv), .bg_color_q(bgc), .bg_hoffset_q(hoff), .bg_voffset_q(voff),
        .residue_addr_q(raddr), .residue_loc_q(rloc), .overlay_addr_q(oaddr),
        .overlay_loc_q(oloc), .overlay_stride_q(ostr), .scale_first_q(sfirst),
        .blend_active_q(bact));

    always #20 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, e);
        chk("rresp", 32'(r), 32'(RESP_OKAY));
    endtask

    // decoded pixel as {alpha, y, u, v}
    function automatic logic [31:0] exp_pix(input logic [2:0] m, input logic [31:0] p);
        logic [3:0] a;
        logic [3:0] i;
        if (m[2]) return p;
        a = m[0] ? p[3:0] : p[7:4];
        i = m[0] ? p[7:4] : p[3:0];
        if (m[1]) a = ~a;
        return {a, a, pal_y[i], pal_u[i], pal_v[i]};
    endfunction

    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #800000;
        num_errors++;
        final_report;
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        logic [31:0] d;
        logic [31:0] v [7];
        logic [1:0] r;
        void'($urandom(82));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (OFFS[i]) rchk("reset", OFFS[i], REG_RESET);
        for (int k = 0; k < 3; k++) begin
            foreach (OFFS[i]) begin
                v[i] = (k == 0) ? 32'hffffffff : $urandom();
                wr(OFFS[i], v[i], 4'hf, r);
                rchk("readback", OFFS[i], v[i] & MASKS[i]);
            end
        end
        chk("bg_color", 32'(bgc), 32'(v[1][29:0]));
        chk("residue", 32'({raddr, rloc}), 32'({v[2][28:4], v[2][1:0]}));
        chk("stride", 32'(ostr), 32'(v[3][13:4]));
        chk("order", 32'(sfirst), 32'(v[3][20]));
        chk("overlay", 32'({oaddr, oloc}), 32'({v[4][28:4], v[4][1:0]}));
        chk("offsets", 32'({hoff, voff}), 32'({v[6][26:16], v[6][10:0]}));
        wr(OFF_BG_COLOR, 32'h0, 4'h1, r);
        rchk("strobe", OFF_BG_COLOR, v[1] & MASK_BG_COLOR & 32'hffffff00);
        wr(12'h000, 32'hffffffff, 4'hf, r);
        chk("wr_unmapped", 32'(r), 32'(RESP_SLVERR));
        rd(12'h000, d, r);
        chk("rd_unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
        for (int i = 0; i < 4; i++) begin
            ofld <= i[0];
            cfld <= ~i[1];
            bufid <= 2'(i);
            rchk("status", OFF_RESIDUE, {i[0], ~i[1], 1'b0, v[2][28:4], 2'(i), v[2][1:0]});
        end
        mcsrc <= 1'b1;
        mcfc <= 8'($urandom());
        fstart <= 1'b1;
        @(posedge sys_clk);
        fstart <= 1'b0;
        wr(OFF_STRIDE_CTRL, 32'h00000000, 4'hf, r);
        rchk("flip_mc", OFF_STRIDE_CTRL, {mcfc, 24'h0});
        mcsrc <= 1'b0;
        yuv <= 1'b1;
        wr(OFF_STRIDE_CTRL, 32'h00010000, 4'hf, r);
        repeat (3) @(posedge sys_clk);
        yuv <= 1'b0;
        chk("blend_yuv", 32'(bact), 32'h1);
        repeat (3) @(posedge sys_clk);
        chk("blend_rgb", 32'(bact), 32'h0);
        for (int e = 0; e < PAL_ENTRIES; e++) begin
            pal_y[e] = 8'($urandom());
            pal_u[e] = 8'($urandom());
            pal_v[e] = 8'($urandom());
            wr(OFF_PALETTE_CTRL, {pal_v[e], pal_u[e], pal_y[e], 4'(e), 4'h7}, 4'hf, r);
        end
        wr(OFF_PALETTE_CTRL, 32'h5a5a5a52, 4'hf, r);
        pal_u[5] = 8'h5a;
        wr(OFF_PALETTE_CTRL, 32'h12345660, 4'hf, r);
        for (int m = 0; m < 8; m++) begin
            wr(OFF_STRIDE_CTRL, {12'h0, 3'(m), 1'b1, 16'h0}, 4'hf, r);
            d = $urandom();
            d[7:0] = (m < 2) ? 8'h55 : d[7:0];
            @(posedge sys_clk);
            pix <= d;
            pvld <= 1'b1;
            @(posedge sys_clk);
            pvld <= 1'b0;
            #1;
            chk("pixel", {pa, py, pu, pv}, exp_pix(3'(m), d));
            chk("pixel_valid", 32'(ovld), 32'h1);
        end
        // vertical stepper: 1:1, a half-step fraction, then random downscale factors
        for (int n = 0; n < 4; n++) begin
            int src, dst, f, ph;
            dst = 16 + $urandom_range(200);
            src = dst + $urandom_range(dst);
            f = (16384 * src + 2 * dst + 1) / (4 * dst + 2);
            f = (n == 0) ? 4096 : (n == 1) ? 4128 : f;
            wr(OFF_VERT_SCALE, 32'h90000000 | 32'(f), 4'hf, r);
            @(posedge sys_clk);
            fstart <= 1'b1;
            @(posedge sys_clk);
            fstart <= 1'b0;
            ph = 0;
            for (int s = 0; s < 6; s++) begin
                lstep <= 1'b1;
                @(posedge sys_clk);
                lstep <= 1'b0;
                ph = ph + f % 4096;
                #1;
                chk("line_inc", 32'(linc), 32'(f / 4096 + ph / 4096));
                ph = ph % 4096;
                chk("weight", 32'(wgt), 32'((ph + 32) / 64));
                @(posedge sys_clk);
            end
        end
        final_report;
    end
endmodule // test_video_subpicture_background_regs
